// *** led_channel.sv ***
// one led channel: trigger source, link transition, behaviour sequencing
// assumes touch is synchronised and pulse_done comes from the period timer
`include "led_link_regs.svh"
`default_nettype none
module led_channel (
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   input  wire logic                     linked,
   input  wire logic                     touch,
   input  wire logic                     host_drive_bit,
   input  wire logic                     invert_link_transition,
   input  wire logic                     duty_mirror_enable,
   input  wire logic                     pulse_done,
   input  wire led_link_pkg::chan_cfg_t  cfg,
   input  wire logic [7:0]               duty_max,
   input  wire logic [7:0]               duty_min,
   output var  led_link_pkg::chan_drive_t drive
);
   logic                      linked_prev_reg;
   logic                      hold_reg;
   logic                      hold_now;
   logic                      demand;
   logic                      demand_prev_reg;
   led_link_pkg::chan_state_t state_reg;
   led_link_pkg::chan_state_t state_next;
   logic                      enter_run;

   // hold decided in the linking cycle itself, so no one-cycle glitch
   assign hold_now = (linked && !linked_prev_reg) ?
                     (cfg.ltran && host_drive_bit && !touch) :
                     (cfg.ltran && hold_reg);

   // linked: touch drives, possibly through the held host state
   always_comb begin
      if (linked) begin
         if (hold_now)
            demand = invert_link_transition ? !touch : 1'b1;
         else
            demand = touch;
      end else begin
         demand = host_drive_bit;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         linked_prev_reg <= 1'b0;
         hold_reg        <= 1'b0;
         demand_prev_reg <= 1'b0;
      end else begin
         linked_prev_reg <= linked;
         hold_reg        <= linked && hold_now;
         demand_prev_reg <= demand;
      end
   end

   // mode read live every cycle, so a new select acts at once
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         led_link_pkg::ST_IDLE: begin
            if (cfg.mode == `MODE_PULSE_ONE) begin
               if (demand && !demand_prev_reg)
                  state_next = led_link_pkg::ST_RUN;
            end else if (demand) begin
               state_next = led_link_pkg::ST_RUN;
            end
         end
         led_link_pkg::ST_RUN: begin
            case (cfg.mode)
               `MODE_PULSE_ONE:
                  if (pulse_done)
                     state_next = led_link_pkg::ST_IDLE;
               `MODE_PULSE_RELEASE:
                  if (!demand)
                     state_next = led_link_pkg::ST_FINISH;
               default:
                  if (!demand)
                     state_next = led_link_pkg::ST_IDLE;
            endcase
         end
         led_link_pkg::ST_FINISH: begin
            if (pulse_done)
               state_next = led_link_pkg::ST_IDLE;
         end
         default: state_next = led_link_pkg::ST_IDLE;
      endcase
   end

   assign enter_run = (state_reg == led_link_pkg::ST_IDLE) &&
                      (state_next == led_link_pkg::ST_RUN);

   // one process owns the whole drive word, so it has one driver
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= led_link_pkg::ST_IDLE;
         drive.actuated <= 1'b0;
         drive.start    <= 1'b0;
         drive.eff_max  <= 8'h00;
         drive.eff_min  <= 8'h00;
      end else begin
         state_reg      <= state_next;
         drive.actuated <= state_next != led_link_pkg::ST_IDLE;
         drive.start    <= enter_run;
         // ramping modes freeze duty at start; direct follows live
         if (enter_run || cfg.mode == `MODE_DIRECT) begin
            drive.eff_max <= duty_mirror_enable ?
                             8'(`DUTY_FULL - duty_max) : duty_max;
            drive.eff_min <= duty_mirror_enable ?
                             8'(`DUTY_FULL - duty_min) : duty_min;
         end
      end
   end
endmodule
`default_nettype wire

// *** led_far_side_model.sv ***
// far side model: touch sensor pads and the pulse period timer
// assumes start pulses come from led_drive and touches from the bench
`default_nettype none
module led_far_side_model #(
   parameter int PULSE_LEN = 20
) (
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic [5:0] touch_cmd,
   input  wire logic [5:0] started,
   output wire logic [5:0] sensor_touch,
   output var  logic [5:0] pulse_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt [6];
   // pad level is asynchronous, the block syncs it
   assign sensor_touch = touch_cmd;
   // one pulse period per start, short so runs stay brief
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= '{default: 0};
         pulse_done <= 6'h00;
      end else begin
         for (int i = 0; i < 6; i++) begin
            pulse_done[i] <= (cnt[i] == 1);
            if (started[i]) begin
               cnt[i] <= PULSE_LEN;
            end else if (cnt[i] > 0) begin
               cnt[i] <= cnt[i] - 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** led_link_ctrl.sv ***
// led link control: register map, mirror tracking, six channel engines
// assumes same-clock host drive, link, polarity and timer inputs;
// touch status arrives from the analog sensing side and is synchronised
`include "led_link_regs.svh"
`default_nettype none
module led_link_ctrl (
   input  wire logic                     clk_sys,
   input  wire logic                     reset_n,
   input  wire logic [7:0]               reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_write,
   input  wire logic                     reg_read,
   output var  logic [7:0]               reg_rdata,
   input  wire logic [5:0]               host_drive_bit,
   input  wire logic [5:0]               sensor_linked,
   input  wire logic [5:0]               sensor_touch,
   input  wire logic [5:0]               polarity_bit,
   input  wire logic                     invert_link_transition,
   input  wire logic                     block_polarity_mirror,
   input  wire logic [5:0]               pulse_done,
   input  wire logic [7:0]               duty_max,
   input  wire logic [7:0]               duty_min,
   output var  logic [5:0]               led_idle_level,
   output var  logic [5:0]               duty_mirror_enable,
   output wire led_link_pkg::chan_drive_t [5:0] led_drive
);
   logic       rst_meta_reg;
   logic       rst_n;
   logic [5:0] linked_transition_control;
   logic [7:0] behaviour_select_low;
   logic [3:0] behaviour_select_high;
   logic [5:0] polarity_prev_reg;
   logic [5:0] polarity_changed;
   logic [5:0] touch_sync;
   logic [5:0] actuated;
   logic [11:0] select_all;
   logic        wr_ltran;
   logic        wr_mirror;
   logic        wr_sel_lo;
   logic        wr_sel_hi;
   led_link_pkg::chan_cfg_t [5:0] chan_cfg;

   // reset assert is immediate, release is synchronised
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // touch comes from another timing domain
   sync_two #(
      .WIDTH (6)
   ) u_touch_sync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (sensor_touch),
      .sync_out (touch_sync)
   );

   // write decode
   assign wr_ltran  = reg_write && reg_addr == `ADDR_LINKED_TRANSITION;
   assign wr_mirror = reg_write && reg_addr == `ADDR_DUTY_MIRROR;
   assign wr_sel_lo = reg_write && reg_addr == `ADDR_SELECT_LOW;
   assign wr_sel_hi = reg_write && reg_addr == `ADDR_SELECT_HIGH;

   // transition control register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         linked_transition_control <= 6'h00;
      else if (wr_ltran)
         linked_transition_control <= reg_wdata[5:0];
   end

   // behaviour select registers, unused high bits never stored
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         behaviour_select_low  <= `REG_RESET;
         behaviour_select_high <= 4'h0;
      end else begin
         if (wr_sel_lo)
            behaviour_select_low <= reg_wdata;
         if (wr_sel_hi)
            behaviour_select_high <= reg_wdata[`SELECT_HIGH_USED-1:0];
      end
   end

   // polarity history for change detection
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         polarity_prev_reg <= 6'h00;
      else
         polarity_prev_reg <= polarity_bit;
   end

   assign polarity_changed = polarity_bit ^ polarity_prev_reg;

   // hardware copy beats a software write in the same cycle,
   // so an unblocked polarity flip is never lost
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         duty_mirror_enable <= 6'h00;
      end else begin
         for (int i = 0; i < `CHANNELS; i++) begin
            if (polarity_changed[i] && !block_polarity_mirror)
               duty_mirror_enable[i] <= polarity_bit[i];
            else if (wr_mirror)
               duty_mirror_enable[i] <= reg_wdata[i];
         end
      end
   end

   // non-actuated pin level: polarity bit set idles low, clear idles high
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         led_idle_level <= 6'h3F;
      else
         led_idle_level <= ~polarity_bit;
   end

   // read answer one cycle after the strobe, unmapped reads zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `REG_RESET;
      end else if (reg_read) begin
         case (reg_addr)
            `ADDR_LINKED_TRANSITION:
               reg_rdata <= {2'h0, linked_transition_control};
            `ADDR_DUTY_MIRROR:
               reg_rdata <= {2'h0, duty_mirror_enable};
            `ADDR_SELECT_LOW:
               reg_rdata <= behaviour_select_low;
            `ADDR_SELECT_HIGH:
               reg_rdata <= {4'h0, behaviour_select_high};
            `ADDR_ACTUATED_STATUS:
               reg_rdata <= {2'h0, actuated};
            default:
               reg_rdata <= `REG_RESET;
         endcase
      end else begin
         reg_rdata <= `REG_RESET;
      end
   end

   assign select_all = {behaviour_select_high, behaviour_select_low};

   // one engine per channel
   genvar g;
   generate
      for (g = 0; g < `CHANNELS; g++) begin : g_chan
         assign chan_cfg[g].ltran = linked_transition_control[g];
         assign chan_cfg[g].mode  = select_all[2*g +: `SELECT_W];
         assign actuated[g]       = led_drive[g].actuated;

         led_channel u_chan (
            .clk_sys                (clk_sys),
            .rst_n                  (rst_n),
            .linked                 (sensor_linked[g]),
            .touch                  (touch_sync[g]),
            .host_drive_bit         (host_drive_bit[g]),
            .invert_link_transition (invert_link_transition),
            .duty_mirror_enable     (duty_mirror_enable[g]),
            .pulse_done             (pulse_done[g]),
            .cfg                    (chan_cfg[g]),
            .duty_max               (duty_max),
            .duty_min               (duty_min),
            .drive                  (led_drive[g])
         );

         // unlinked direct: drive bit rise actuates next cycle
         property p_host_touch;
            @(posedge clk_sys) disable iff (!rst_n)
            (!sensor_linked[g] && $past(!sensor_linked[g]) &&
             chan_cfg[g].mode == `MODE_DIRECT && $rose(host_drive_bit[g]))
            |-> ##1 led_drive[g].actuated;
         endproperty
         a_host_touch: assert property (p_host_touch)
            else $error("drive bit set did not actuate");

         // unlinked direct: drive bit fall releases next cycle
         property p_host_release;
            @(posedge clk_sys) disable iff (!rst_n)
            (!sensor_linked[g] && $past(!sensor_linked[g]) &&
             chan_cfg[g].mode == `MODE_DIRECT && $fell(host_drive_bit[g]))
            |=> !led_drive[g].actuated;
         endproperty
         a_host_release: assert property (p_host_release)
            else $error("drive bit clear did not release");

         // single pulse holds until the timer reports done
         property p_pulse_hold;
            @(posedge clk_sys) disable iff (!rst_n)
            (led_drive[g].actuated && !pulse_done[g] &&
             chan_cfg[g].mode == `MODE_PULSE_ONE)
            |=> led_drive[g].actuated;
         endproperty
         a_pulse_hold: assert property (p_pulse_hold)
            else $error("single pulse cut short");

         // linking with transition bit clear drops a host-on led
         property p_link_change;
            @(posedge clk_sys) disable iff (!rst_n)
            ($rose(sensor_linked[g]) && host_drive_bit[g] &&
             !touch_sync[g] && !linked_transition_control[g] &&
             chan_cfg[g].mode == `MODE_DIRECT)
            |=> !led_drive[g].actuated;
         endproperty
         a_link_change: assert property (p_link_change)
            else $error("linking did not change led state");

         // linking with transition bit set keeps a host-on led
         property p_link_keep;
            @(posedge clk_sys) disable iff (!rst_n)
            ($rose(sensor_linked[g]) && host_drive_bit[g] &&
             !touch_sync[g] && linked_transition_control[g] &&
             chan_cfg[g].mode == `MODE_DIRECT)
            |=> led_drive[g].actuated;
         endproperty
         a_link_keep: assert property (p_link_keep)
            else $error("linking changed a held led");

         // linked plain direct: host bit has no say
         property p_linked_no_host;
            @(posedge clk_sys) disable iff (!rst_n)
            (sensor_linked[g] && $past(sensor_linked[g], 2) &&
             $past(sensor_linked[g]) && !linked_transition_control[g] &&
             chan_cfg[g].mode == `MODE_DIRECT && !touch_sync[g] &&
             $stable(touch_sync[g]))
            |=> !led_drive[g].actuated;
         endproperty
         a_linked_no_host: assert property (p_linked_no_host)
            else $error("linked led followed host bit");

         // mirrored direct duty is the complement of the setting
         property p_mirror_duty;
            @(posedge clk_sys) disable iff (!rst_n)
            (duty_mirror_enable[g] && chan_cfg[g].mode == `MODE_DIRECT)
            |=> led_drive[g].eff_max == 8'(`DUTY_FULL - $past(duty_max));
         endproperty
         a_mirror_duty: assert property (p_mirror_duty)
            else $error("mirrored duty wrong");

         // breathing duty frozen while actuated
         property p_duty_frozen;
            @(posedge clk_sys) disable iff (!rst_n)
            (led_drive[g].actuated && !led_drive[g].start &&
             chan_cfg[g].mode == `MODE_BREATHE && $past(chan_cfg[g].mode)
             == `MODE_BREATHE)
            |-> $stable(led_drive[g].eff_max);
         endproperty
         a_duty_frozen: assert property (p_duty_frozen)
            else $error("duty changed mid breathe");

         // pulse on release runs on until the timer reports done
         property p_release_finish;
            @(posedge clk_sys) disable iff (!rst_n)
            (led_drive[g].actuated && !pulse_done[g] &&
             chan_cfg[g].mode == `MODE_PULSE_RELEASE)
            |=> led_drive[g].actuated;
         endproperty
         a_release_finish: assert property (p_release_finish)
            else $error("pulse after release cut short");

         // start marks one cycle, the first of an actuated run
         property p_start_once;
            @(posedge clk_sys) disable iff (!rst_n)
            led_drive[g].start
            |-> led_drive[g].actuated ##1 !led_drive[g].start;
         endproperty
         a_start_once: assert property (p_start_once)
            else $error("start pulse malformed");
      end
   endgenerate

   // written transition bits read back unchanged
   // reached when the read follows the write with no gap
   property p_ltran_readback;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_ltran ##1 (reg_read && reg_addr == `ADDR_LINKED_TRANSITION
                     && !reg_write))
      |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3F);
   endproperty
   a_ltran_readback: assert property (p_ltran_readback)
      else $error("transition register readback wrong");

   // polarity flip copies into mirror unless blocked
   property p_mirror_follow;
      @(posedge clk_sys) disable iff (!rst_n)
      (polarity_changed[0] && !block_polarity_mirror)
      |=> duty_mirror_enable[0] == $past(polarity_bit[0]);
   endproperty
   a_mirror_follow: assert property (p_mirror_follow)
      else $error("mirror did not track polarity");

   // blocked mirror only moves on a software write
   property p_mirror_blocked;
      @(posedge clk_sys) disable iff (!rst_n)
      (block_polarity_mirror && !wr_mirror) |=> $stable(duty_mirror_enable);
   endproperty
   a_mirror_blocked: assert property (p_mirror_blocked)
      else $error("mirror changed without write");

   // a software write lands when no polarity copy competes
   // with it in the same cycle
   property p_mirror_write;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_mirror && (block_polarity_mirror ||
                     polarity_changed == 6'h00))
      |=> duty_mirror_enable == $past(reg_wdata[5:0]);
   endproperty
   a_mirror_write: assert property (p_mirror_write)
      else $error("mirror write lost");

   // status read shows which channels are actuated
   // the status word is read-only, writes to it fall through
   property p_status_read;
      @(posedge clk_sys) disable iff (!rst_n)
      (reg_read && reg_addr == `ADDR_ACTUATED_STATUS)
      |=> reg_rdata == {2'h0, $past(actuated)};
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("actuated status readback wrong");

   // high select register keeps its upper nibble at zero
   property p_sel_high_upper;
      @(posedge clk_sys) disable iff (!rst_n)
      (reg_read && reg_addr == `ADDR_SELECT_HIGH) |=> reg_rdata[7:4] == 4'h0;
   endproperty
   a_sel_high_upper: assert property (p_sel_high_upper)
      else $error("unused select bits not zero");

   // idle level tracks polarity one cycle later
   property p_idle_level;
      @(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> led_idle_level == ~$past(polarity_bit);
   endproperty
   a_idle_level: assert property (p_idle_level)
      else $error("idle level does not follow polarity");
endmodule
`default_nettype wire

// *** led_link_ctrl_tb_top.sv ***
// self-checking bench of the led link control block, channel 0 mostly
// assumes the far side model supplies touch and pulse_done
`default_nettype none
module led_link_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys = 1'b0;
   logic       reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic [5:0] host_drive_bit = 6'h00;
   logic [5:0] sensor_linked = 6'h00;
   logic [5:0] polarity_bit = 6'h00;
   logic       invert_link_transition = 1'b0;
   logic       block_polarity_mirror = 1'b0;
   logic [7:0] duty_max = 8'h50;
   logic [7:0] duty_min = 8'h0A;
   logic [5:0] touch_cmd = 6'h00;
   logic [5:0] sensor_touch, pulse_done, started;
   logic [5:0] led_idle_level, duty_mirror_enable;
   led_link_pkg::chan_drive_t [5:0] led_drive;
   int         n_errors = 0;
   int         total_checks = 0;

   always #2 clk_sys = ~clk_sys;
   for (genvar g = 0; g < 6; g++) begin : g_st
      assign started[g] = led_drive[g].start;
   end

   led_link_ctrl uut (.clk_sys(clk_sys), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata),
      .host_drive_bit(host_drive_bit), .sensor_linked(sensor_linked),
      .sensor_touch(sensor_touch), .polarity_bit(polarity_bit),
      .invert_link_transition(invert_link_transition),
      .block_polarity_mirror(block_polarity_mirror),
      .pulse_done(pulse_done), .duty_max(duty_max), .duty_min(duty_min),
      .led_idle_level(led_idle_level),
      .duty_mirror_enable(duty_mirror_enable), .led_drive(led_drive));
   led_far_side_model #(.PULSE_LEN(20)) far (.clk_sys(clk_sys),
      .reset_n(reset_n), .touch_cmd(touch_cmd), .started(started),
      .sensor_touch(sensor_touch), .pulse_done(pulse_done));

   // settle past the edge before looking
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic act(input logic exp);
      chk("actuated", {7'h00, exp}, {7'h00, led_drive[0].actuated});
   endtask
   // one-cycle strobes, signals held to the sampling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1;
      chk("reg_rdata", exp, reg_rdata);
   endtask
   // host-on channel gets linked, then its pad is touched and released
   task automatic link_case(input logic lt, input logic inv,
                            input logic on_link, input logic on_touch);
      wr(8'h77, {7'h00, lt});
      invert_link_transition <= inv;
      host_drive_bit <= 6'h01;
      step(3);
      act(1'b1);
      @(posedge clk_sys);
      sensor_linked <= 6'h01;
      step(3);
      act(on_link);
      touch_cmd <= 6'h01;
      step(5);
      act(on_touch);
      touch_cmd <= 6'h00;
      step(5);
      sensor_linked <= 6'h00;
      host_drive_bit <= 6'h00;
      step(3);
      act(1'b0);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // run is a few hundred cycles, so 50000 means a hang
   initial begin
      #200us;
      n_errors++;
      $display("CHECK FAILED watchdog expected finish seen hang");
      wrap_up();
   end

   initial begin
      step(16);
      reset_n <= 1'b1;
      step(4);
      rd(8'h77, 8'h00);
      rd(8'h79, 8'h00);
      rd(8'h81, 8'h00);
      rd(8'h82, 8'h00);
      wr(8'h77, 8'hFF);
      rd(8'h77, 8'h3F);
      wr(8'h82, 8'hFF);
      rd(8'h82, 8'h0F);
      wr(8'h81, 8'hA5);
      rd(8'h81, 8'hA5);
      wr(8'h78, 8'h5A);
      rd(8'h78, 8'h00);
      wr(8'h81, 8'h00);
      link_case(1'b0, 1'b1, 1'b0, 1'b1);
      link_case(1'b1, 1'b1, 1'b1, 1'b0);
      link_case(1'b1, 1'b0, 1'b1, 1'b1);
      // single pulse: toggles while running are dropped
      wr(8'h81, 8'h01);
      invert_link_transition <= 1'b1;
      host_drive_bit <= 6'h01;
      step(3);
      act(1'b1);
      host_drive_bit <= 6'h00;
      step(2);
      host_drive_bit <= 6'h01;
      step(2);
      host_drive_bit <= 6'h00;
      act(1'b1);
      step(30);
      act(1'b0);
      // pulse on release: runs on after the clear until done
      wr(8'h81, 8'h02);
      host_drive_bit <= 6'h01;
      step(1);
      act(1'b1);
      chk("start", 8'h01, {7'h00, led_drive[0].start});
      host_drive_bit <= 6'h00;
      step(3);
      act(1'b1);
      rd(8'h8E, 8'h01);
      step(25);
      act(1'b0);
      // breathe starts on set, stops on clear
      wr(8'h81, 8'h03);
      host_drive_bit <= 6'h01;
      step(3);
      act(1'b1);
      host_drive_bit <= 6'h00;
      step(3);
      act(1'b0);
      // polarity copies into mirror unless blocked
      wr(8'h81, 8'h00);
      polarity_bit <= 6'h01;
      host_drive_bit <= 6'h01;
      step(3);
      rd(8'h79, 8'h01);
      chk("mirror_port", 8'h01, {2'b00, duty_mirror_enable});
      chk("idle", 8'h3E, {2'b00, led_idle_level});
      chk("eff_max", 8'h14, led_drive[0].eff_max);
      chk("eff_min", 8'h5A, led_drive[0].eff_min);
      block_polarity_mirror <= 1'b1;
      polarity_bit <= 6'h00;
      step(3);
      rd(8'h79, 8'h01);
      chk("idle", 8'h3F, {2'b00, led_idle_level});
      wr(8'h79, 8'h00);
      step(3);
      chk("eff_max", 8'h50, led_drive[0].eff_max);
      wrap_up();
   end
endmodule
`default_nettype wire

// *** led_link_pkg.sv ***
// shared types of the led link block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package led_link_pkg;
   typedef enum {ST_IDLE, ST_RUN, ST_FINISH} chan_state_t;

   typedef struct packed {
      logic       ltran;
      logic [1:0] mode;
   } chan_cfg_t;

   typedef struct packed {
      logic       actuated;
      logic       start;
      logic [7:0] eff_max;
      logic [7:0] eff_min;
   } chan_drive_t;
endpackage
`default_nettype wire

// *** led_link_regs.svh ***
// offsets, field layout, reset values and codes of the led link block
// assumes the includer wants plain `define constants only
//
// Contract
// - per-channel linked-transition bits, reset zero
// - bit clear: linking while host-on changes LED
// - bit set, invert set: hold, touch toggles
// - bit set, invert clear: hold, touch ignored
// - mirror bits: duty relative 0% or 100%
// - polarity change copies into mirror unless blocked
// - two behaviour select registers, 2-bit fields
// - linked channel triggered by touch and release
// - unlinked channel: drive bit acts as touch
// - behaviour starts on start, ends on stop
// - idle pin level follows channel polarity
// - unlinked breathe/pulse ignores settings until re-actuated
// - unlinked single pulse ignores drive until finished
// - behaviour change applies immediately
// - source switch: pulses finish, others follow
// - inactive new source acts as release
// - select decode: direct, pulse, pulse-release, breathe
// - linked channel ignores host drive bit
`ifndef LED_LINK_REGS_SVH
`define LED_LINK_REGS_SVH

`define ADDR_LINKED_TRANSITION 8'h77
`define ADDR_DUTY_MIRROR       8'h79
`define ADDR_SELECT_LOW        8'h81
`define ADDR_SELECT_HIGH       8'h82
`define ADDR_ACTUATED_STATUS   8'h8E

`define REG_RESET              8'h00
`define CHANNELS               6
`define SELECT_W               2
`define SELECT_HIGH_USED       4
`define DUTY_FULL              8'h64

`define MODE_DIRECT            2'h0
`define MODE_PULSE_ONE         2'h1
`define MODE_PULSE_RELEASE     2'h2
`define MODE_BREATHE           2'h3

`endif

// *** sync_two.sv ***
// two-stage synchroniser for a bundle of level signals
// assumes each bit is an independent slow level
`default_nettype none
module sync_two #(
   parameter int WIDTH = 6
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire
